// [fcrc_cfg.svh]
`ifndef FCRC_CFG_SVH
`define FCRC_CFG_SVH

`define FCRC_WORD_W 32
`define FCRC_FIFO_DEPTH 8
`define FCRC_POLY 32'h04C11DB7
`define FCRC_PRESET 32'hFFFFFFFF
`define FCRC_RESIDUE 32'hC704DD7B
`define FCRC_SAMPLE_CHECK 32'h9B61F408
`define FCRC_SAMPLE_W0 32'hC0010203
`define FCRC_SAMPLE_W1 32'h00040506
`define FCRC_SAMPLE_W2 32'h00C00000
`define FCRC_SAMPLE_W3 32'h02000003
`define FCRC_SAMPLE_W4 32'hFFFFFFFF
`define FCRC_SAMPLE_W5 32'h00000001

`endif

// [fcrc_pkg.sv]
`include "fcrc_cfg.svh"
package fcrc_pkg;

   typedef enum logic [1:0] {
      FCRC_TX_DATA = 2'b01,
      FCRC_TX_CHECK = 2'b10
   } fcrc_tx_state_e;

   typedef logic [31:0] fcrc_word_t;

   // Advances the remainder over one word in line order: byte lanes from
   // the top down, each lane least significant bit first
   function automatic fcrc_word_t fcrc_word_step(input fcrc_word_t crc, input fcrc_word_t word);
      fcrc_word_t c;
      logic fb;
      c = crc;
      for (int i = 0; i < 32; i++) begin
         fb = c[31] ^ word[(3 - i / 8) * 8 + (i % 8)];
         c = {c[30:0], 1'b0} ^ (fb ? `FCRC_POLY : 32'h00000000);
      end
      return c;
   endfunction

   // Places a remainder so that its degree 31 coefficient lands on the first line bit
   function automatic fcrc_word_t fcrc_lane_swap(input fcrc_word_t r);
      fcrc_word_t w;
      w = 32'h00000000;
      for (int i = 0; i < 32; i++) begin
         w[(3 - i / 8) * 8 + (i % 8)] = r[31 - i];
      end
      return w;
   endfunction

endpackage

// [fcrc_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module fcrc_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;

   ////////////////////////////////////////////////////////////////////////
   // Full and empty come straight from the count, so they never lie
   assign in_ready = (cnt_reg != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rd_reg];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Pointer and count update
   always_comb begin
      wr_next = wr_reg;
      rd_next = rd_reg;
      cnt_next = cnt_reg;
      if (push) begin
         wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
      end
      if (pop) begin
         rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + (AW+1)'(1);
      end else if (pop && !push) begin
         cnt_next = cnt_reg - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   // Storage has no reset; only written slots are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end
endmodule
`default_nettype wire

// [fcrc_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fcrc_cfg.svh"
module fcrc_top
   import fcrc_pkg::*;
#(
   parameter int DEPTH = `FCRC_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   // Covered words from the framing logic, outbound
   input wire logic tx_in_valid,
   output logic tx_in_ready,
   input wire logic [31:0] tx_in_data,
   input wire logic tx_in_last,
   // Words toward the line coder, check field appended
   output logic tx_out_valid,
   input wire logic tx_out_ready,
   output logic [31:0] tx_out_data,
   output logic tx_out_check,
   // Received covered words plus check field
   input wire logic rx_valid,
   input wire logic [31:0] rx_data,
   input wire logic rx_last,
   output logic rx_good,
   output logic rx_err,
   output logic [31:0] rx_remainder
);

   ////////////////////////////////////////////////////////////////////////
   // Transmit buffer: absorbs stalls from the line coder
   logic fifo_valid, fifo_ready;
   logic [32:0] fifo_data;

   fcrc_fifo #(
      .WIDTH(33),
      .DEPTH(DEPTH)
   ) fcrc_fifo_i (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(tx_in_valid),
      .in_ready(tx_in_ready),
      .in_data({tx_in_last, tx_in_data}),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Transmit generator state
   fcrc_tx_state_e state_reg, state_next;
   logic [31:0] crc_reg, crc_next;
   logic [31:0] out_data_reg, out_data_next;
   logic out_valid_reg, out_valid_next;
   logic out_check_reg, out_check_next;
   logic can_load, pop, check_load;

   // Output stage takes a new word when empty or being drained
   assign can_load = !out_valid_reg || tx_out_ready;
   assign fifo_ready = (state_reg == FCRC_TX_DATA) && can_load;
   assign pop = fifo_valid && fifo_ready;
   assign check_load = (state_reg == FCRC_TX_CHECK) && can_load;

   // Next-state: data words pass and fold into the remainder; the check
   // field is inserted as soon as the last covered word has gone
   always_comb begin
      state_next = state_reg;
      crc_next = crc_reg;
      out_data_next = out_data_reg;
      out_check_next = out_check_reg;
      out_valid_next = out_valid_reg && !tx_out_ready;
      case (state_reg)
         FCRC_TX_DATA: begin
            if (pop) begin
               out_data_next = fifo_data[31:0];
               out_check_next = 1'b0;
               out_valid_next = 1'b1;
               crc_next = fcrc_word_step(crc_reg, fifo_data[31:0]);
               if (fifo_data[32]) begin
                  state_next = FCRC_TX_CHECK;
               end
            end
         end
         FCRC_TX_CHECK: begin
            if (can_load) begin
               out_data_next = fcrc_lane_swap(~crc_reg);
               out_check_next = 1'b1;
               out_valid_next = 1'b1;
               crc_next = `FCRC_PRESET;
               state_next = FCRC_TX_DATA;
            end
         end
         default: begin
            state_next = FCRC_TX_DATA;
            crc_next = `FCRC_PRESET;
            out_valid_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= FCRC_TX_DATA;
         crc_reg <= `FCRC_PRESET;
         out_data_reg <= 32'h00000000;
         out_valid_reg <= 1'b0;
         out_check_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         crc_reg <= crc_next;
         out_data_reg <= out_data_next;
         out_valid_reg <= out_valid_next;
         out_check_reg <= out_check_next;
      end
   end

   assign tx_out_valid = out_valid_reg;
   assign tx_out_data = out_data_reg;
   assign tx_out_check = out_check_reg;

   ////////////////////////////////////////////////////////////////////////
   // Receive checker: no back-pressure, one word per valid cycle
   logic [31:0] rx_crc_reg, rx_crc_next, rx_rem_reg, rx_rem_next;
   logic rx_good_reg, rx_good_next, rx_err_reg, rx_err_next;
   logic [31:0] rx_step;

   assign rx_step = fcrc_word_step(rx_crc_reg, rx_data);

   // Check field runs through the same divider; the residue is fixed
   always_comb begin
      rx_crc_next = rx_crc_reg;
      rx_rem_next = rx_rem_reg;
      rx_good_next = 1'b0;
      rx_err_next = 1'b0;
      if (rx_valid) begin
         rx_crc_next = rx_step;
         if (rx_last) begin
            rx_rem_next = rx_step;
            rx_good_next = (rx_step == `FCRC_RESIDUE);
            rx_err_next = (rx_step != `FCRC_RESIDUE);
            rx_crc_next = `FCRC_PRESET;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_crc_reg <= `FCRC_PRESET;
         rx_rem_reg <= 32'h00000000;
         rx_good_reg <= 1'b0;
         rx_err_reg <= 1'b0;
      end else begin
         rx_crc_reg <= rx_crc_next;
         rx_rem_reg <= rx_rem_next;
         rx_good_reg <= rx_good_next;
         rx_err_reg <= rx_err_next;
      end
   end

   assign rx_good = rx_good_reg;
   assign rx_err = rx_err_reg;
   assign rx_remainder = rx_rem_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks on the generator and checker
   // Fold of the sample header, evaluated on constants only
   logic [31:0] sample_crc;
   always_comb begin
      sample_crc = `FCRC_PRESET;
      sample_crc = fcrc_word_step(sample_crc, `FCRC_SAMPLE_W0);
      sample_crc = fcrc_word_step(sample_crc, `FCRC_SAMPLE_W1);
      sample_crc = fcrc_word_step(sample_crc, `FCRC_SAMPLE_W2);
      sample_crc = fcrc_word_step(sample_crc, `FCRC_SAMPLE_W3);
      sample_crc = fcrc_word_step(sample_crc, `FCRC_SAMPLE_W4);
      sample_crc = fcrc_word_step(sample_crc, `FCRC_SAMPLE_W5);
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_last_pop;
      pop && fifo_data[32];
   endsequence

   sequence s_check_out;
      check_load ##1 (tx_out_valid && tx_out_check);
   endsequence

   a_sample_value: assert property (~sample_crc == `FCRC_SAMPLE_CHECK)
      else $error("sample header check value wrong");

   // A stalled line coder may delay the check field, but no covered word may slip in first
   a_check_follows: assert property (s_last_pop |=> state_reg == FCRC_TX_CHECK && !fifo_ready)
      else $error("check field did not follow last word");

   a_check_value: assert property (check_load |=> tx_out_data == fcrc_lane_swap(~$past(crc_reg)))
      else $error("check field is not inverted remainder");

   a_tx_preset: assert property (s_check_out |-> crc_reg == `FCRC_PRESET)
      else $error("generator not preset after check field");

   a_crc_step: assert property (pop |=> crc_reg == fcrc_word_step($past(crc_reg), $past(fifo_data[31:0])))
      else $error("generator remainder not advanced");

   a_data_pass: assert property (pop |=> tx_out_valid && !tx_out_check && tx_out_data == $past(fifo_data[31:0]))
      else $error("covered word altered on way out");

   a_out_hold: assert property (tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out_data))
      else $error("output word dropped under stall");

   a_rx_preset: assert property (rx_valid && rx_last |=> rx_crc_reg == `FCRC_PRESET)
      else $error("checker not preset after frame");

   a_rx_verdict: assert property (rx_valid && rx_last |=> (rx_err != (rx_remainder == `FCRC_RESIDUE)) && (rx_good ^ rx_err))
      else $error("checker verdict wrong");

   a_err_pulse: assert property (rx_err && !$past(rx_valid && rx_last) |-> 1'b0)
      else $error("error flag without end of frame");

endmodule
`default_nettype wire

// [fcrc_line_sink.sv]
`timescale 1ns/1ps
`default_nettype none
module fcrc_line_sink (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] mode,
   input wire logic valid,
   input wire logic [31:0] data,
   input wire logic check,
   output logic ready
);
   logic [32:0] got[$];
   logic tog = 1'b0;
   initial ready = 1'b0;
   ////////////////////////
   // Ready pattern: 0 prompt, 1 every other cycle, 2 stalled
   always @(negedge clk) begin
      tog <= ~tog;
      ready <= rst_n && (mode == 2'h0 || (mode == 2'h1 && tog));
   end
   // Words kept whole; serialising happens further down the line
   always @(posedge clk) begin
      if (rst_n && valid && ready) begin
         got.push_back({check, data});
      end
   end
endmodule
`default_nettype wire

// [fcrc_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fcrc_cfg.svh"
module fcrc_top_bench
   import fcrc_pkg::*;
;
   localparam int DEPTH = `FCRC_FIFO_DEPTH;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic tx_in_valid = 1'b0;
   logic tx_in_last = 1'b0;
   logic rx_valid = 1'b0;
   logic rx_last = 1'b0;
   logic [31:0] tx_in_data = 32'h00000000;
   logic [31:0] rx_data = 32'h00000000;
   logic [1:0] sink_mode = 2'h0;
   logic tx_in_ready, tx_out_valid, tx_out_ready, tx_out_check, rx_good, rx_err;
   logic [31:0] tx_out_data, rx_remainder;
   int err_total = 0;
   int checked = 0;
   fcrc_word_t sample_q[$] = '{`FCRC_SAMPLE_W0, `FCRC_SAMPLE_W1, `FCRC_SAMPLE_W2,
                               `FCRC_SAMPLE_W3, `FCRC_SAMPLE_W4, `FCRC_SAMPLE_W5};

   always #5 clk = ~clk;

   fcrc_top #(.DEPTH(DEPTH)) fcrc_top_i (.clk(clk), .rst_n(rst_n),
      .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_in_data(tx_in_data),
      .tx_in_last(tx_in_last), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
      .tx_out_data(tx_out_data), .tx_out_check(tx_out_check), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_last(rx_last), .rx_good(rx_good), .rx_err(rx_err),
      .rx_remainder(rx_remainder));
   fcrc_line_sink fcrc_line_sink_i (.clk(clk), .rst_n(rst_n), .mode(sink_mode),
      .valid(tx_out_valid), .data(tx_out_data), .check(tx_out_check), .ready(tx_out_ready));
   ////////////////////////
   // Reference remainder step, written apart from the design's own helper
   function automatic fcrc_word_t tb_crc(input fcrc_word_t c, input fcrc_word_t w);
      logic fb;
      for (int b = 3; b >= 0; b--) begin
         for (int i = 0; i < 8; i++) begin
            fb = c[31] ^ w[b * 8 + i];
            c = {c[30:0], 1'b0} ^ (fb ? `FCRC_POLY : 32'h00000000);
         end
      end
      return c;
   endfunction
   // Each byte mirrored so degree 31 lands on bit 24
   function automatic fcrc_word_t tb_lay(input fcrc_word_t v);
      fcrc_word_t o;
      for (int i = 0; i < 32; i++) begin
         o[i] = v[(i / 8) * 8 + 7 - (i % 8)];
      end
      return o;
   endfunction
   function automatic fcrc_word_t tb_field(input fcrc_word_t f[$]);
      fcrc_word_t r = `FCRC_PRESET;
      foreach (f[k]) r = tb_crc(r, f[k]);
      return tb_lay(~r);
   endfunction
   ////////////////////////
   task automatic cmp_w(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmp_b(input string n, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic hang(input string n);
      err_total++;
      $display("[FAIL] %s expected handshake seen none", n);
      tally_and_finish();
   endtask
   ////////////////////////
   // Valid stays up on return so back-to-back words never glitch it
   task automatic push(input fcrc_word_t w, input logic last);
      int n;
      n = 0;
      tx_in_valid = 1'b1;
      tx_in_data = w;
      tx_in_last = last;
      while (tx_in_ready !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > 200) hang("tx_in_ready");
      end
      @(negedge clk);
   endtask
   task automatic send_frame(input fcrc_word_t f[$]);
      foreach (f[k]) push(f[k], k == f.size() - 1);
   endtask
   task automatic expect_tx(input fcrc_word_t f[$], input int base, input fcrc_word_t field);
      int n;
      n = 0;
      while (fcrc_line_sink_i.got.size() < base + f.size() + 1) begin
         @(negedge clk);
         n++;
         if (n > 400) hang("tx_out_valid");
      end
      foreach (f[k]) begin
         cmp_w("tx_out_data", f[k], fcrc_line_sink_i.got[base + k][31:0]);
         cmp_b("tx_out_check", 1'b0, fcrc_line_sink_i.got[base + k][32]);
      end
      cmp_w("check field", field, fcrc_line_sink_i.got[base + f.size()][31:0]);
      cmp_b("tx_out_check", 1'b1, fcrc_line_sink_i.got[base + f.size()][32]);
   endtask
   task automatic rx_frame(input fcrc_word_t f[$], input fcrc_word_t field);
      fcrc_word_t r;
      r = `FCRC_PRESET;
      f.push_back(field);
      foreach (f[k]) begin
         r = tb_crc(r, f[k]);
         rx_valid = 1'b1;
         rx_data = f[k];
         rx_last = (k == f.size() - 1);
         @(negedge clk);
      end
      rx_valid = 1'b0;
      rx_last = 1'b0;
      cmp_b("rx_good", r == `FCRC_RESIDUE, rx_good);
      cmp_b("rx_err", r != `FCRC_RESIDUE, rx_err);
      cmp_w("rx_remainder", r, rx_remainder);
      @(negedge clk);
      cmp_b("rx pulse end", 1'b0, rx_err | rx_good);
   endtask
   ////////////////////////
   // Sample header then a one-word frame straight behind it
   task automatic s_sample();
      fcrc_word_t qb[$] = '{32'h80000000};
      send_frame(sample_q);
      send_frame(qb);
      tx_in_valid = 1'b0;
      expect_tx(sample_q, 0, tb_lay(`FCRC_SAMPLE_CHECK));
      expect_tx(qb, 7, tb_field(qb));
   endtask
   // Line coder stalled until the buffer refuses, then drained slowly
   task automatic s_fill();
      fcrc_word_t qc[$];
      int k;
      int base;
      for (int i = 0; i < 12; i++) qc.push_back(32'h01020304 * (i + 1));
      base = fcrc_line_sink_i.got.size();
      sink_mode = 2'h2;
      k = 0;
      tx_in_valid = 1'b1;
      tx_in_last = 1'b0;
      while (k < 12 && tx_in_ready === 1'b1) begin
         tx_in_data = qc[k];
         @(negedge clk);
         k++;
      end
      cmp_b("tx_in_ready full", 1'b0, tx_in_ready);
      cmp_b("fill depth", 1'b1, k >= DEPTH && k <= DEPTH + 2);
      sink_mode = 2'h1;
      for (int i = k; i < 12; i++) push(qc[i], i == 11);
      tx_in_valid = 1'b0;
      expect_tx(qc, base, tb_field(qc));
      @(negedge clk);
      cmp_b("tx_out_valid drained", 1'b0, tx_out_valid);
   endtask
   // Leading zeros must not pass without the all-ones preset
   task automatic s_rx();
      fcrc_word_t qz[$] = '{32'h00000000, 32'h00000000, 32'h00000000};
      rx_frame(sample_q, tb_lay(`FCRC_SAMPLE_CHECK));
      rx_frame(sample_q, tb_lay(`FCRC_SAMPLE_CHECK) ^ 32'h00000100);
      rx_frame(qz, tb_field(qz));
      rx_frame(qz, 32'h00000000);
   endtask
   ////////////////////////
   initial begin
      repeat (8) @(negedge clk);
      cmp_b("tx_in_ready reset", 1'b1, tx_in_ready);
      cmp_b("tx_out_valid reset", 1'b0, tx_out_valid);
      cmp_w("rx_remainder reset", 32'h00000000, rx_remainder);
      rst_n = 1'b1;
      s_sample();
      s_fill();
      s_rx();
      tally_and_finish();
   end
endmodule
`default_nettype wire
